// >>> hw/msc_sa_context.sv
// Notes on behaviour
// RQ1 - Software sets IV word flags one, one, zero
// RQ2 - Software sets sequence-update and IV-format bits
// RQ3 - Software sets encrypt-ICV and key-load bits
// RQ4 - Decode algorithm field: AES-128 or AES-256
// RQ5 - Software programs single digest key, GHASH
// RQ6 - Egress tag carries association number field
// RQ7 - Software selects 32-bit sequence type
// RQ8 - Mask-present bit marks ingress versus egress
// RQ9 - Context identifier present and unique
// RQ10 - Key words are little-endian byte quads
// RQ11 - Software supplies hash key, same order
// RQ12 - Egress sequence holds PN minus one
// RQ13 - Rollover flags error, context left unchanged
// RQ14 - Software starts ingress sequence at one
// RQ15 - Replay window resets to zero, strict
// RQ16 - Channel identifier stored as two words
// RQ17 - Software replaces SA before rollover
// RQ18 - In-order PN writes back PN plus one
// RQ19 - In-window late PN accepted, no update
// RQ20 - Too-old PN fails with replay flag
// RQ21 - Threshold crossing sets status bit four
// RQ22 - Egress wrap sets status bit five
// RQ23 - Status bits sticky; enabled ones drive interrupt
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module msc_sa_context (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pkt_valid,
    input wire logic [31:0] pkt_number,
    output logic res_valid,
    output logic res_seq_error,
    output logic res_replay_error_flag,
    output logic [31:0] res_packet_number,
    output logic [1:0] res_association_number,
    output logic [63:0] res_secure_channel_identifier,
    output logic res_key_256,
    output logic res_alg_invalid,
    output logic crypto_irq
);
    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] ctx_id;
        logic [31:0] seq;
        logic [31:0] mask;
        logic [31:0] sci_lo;
        logic [31:0] sci_hi;
        logic [31:0] thresh;
        logic [1:0] int_status;
        logic [1:0] int_en;
        logic seq_err_sticky;
        logic replay_err_sticky;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic res_valid;
        logic res_seq_error;
        logic res_replay;
        logic [31:0] res_pn;
        logic [1:0] res_an;
        logic [63:0] res_sci;
        logic res_key_256;
        logic res_alg_invalid;
        logic irq;
    } msc_state_s;

    msc_state_s cur;
    msc_state_s next_cur;
    // End of the key and hash key words; addresses from here up to OFF_SEQ are unmapped
    localparam logic [7:0] KEY_END =
        8'(msc_pkg::OFF_KEY0 + 4 * (msc_pkg::KEY_WORDS + msc_pkg::HKEY_WORDS));
    // Key and hash key words live in a small array outside the struct
    logic [31:0] key_mem [0:msc_pkg::KEY_WORDS + msc_pkg::HKEY_WORDS - 1];

    logic [31:0] eg_next;
    logic eg_roll;
    logic eg_thresh;
    logic ig_advance;
    logic ig_fail;
    logic [31:0] ig_new_next;
    logic is_ingress;
    logic setup_req;
    logic wr_acc;
    logic rd_acc;
    logic key_hit;
    logic [3:0] key_idx;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic alg_is_256(input logic [31:0] cw);
        return cw[msc_pkg::CW_ALG_HI:msc_pkg::CW_ALG_LO] == msc_pkg::ALG_AES256;
    endfunction

    function automatic logic alg_is_valid(input logic [31:0] cw);
        return (cw[msc_pkg::CW_ALG_HI:msc_pkg::CW_ALG_LO] == msc_pkg::ALG_AES128) ||
               alg_is_256(cw);
    endfunction

    function automatic logic key_range(input logic [7:0] a);
        return (a >= msc_pkg::OFF_KEY0) && (a < KEY_END) && (a[1:0] == 2'b00);
    endfunction

    function automatic logic addr_is_mapped(input logic [7:0] a);
        logic hit;
        hit = key_range(a);
        case (a)
            msc_pkg::OFF_CTRL, msc_pkg::OFF_CTX_ID, msc_pkg::OFF_SEQ,
            msc_pkg::OFF_MASK, msc_pkg::OFF_SCI_LO, msc_pkg::OFF_SCI_HI,
            msc_pkg::OFF_THRESH, msc_pkg::OFF_INTR, msc_pkg::OFF_STATUS: hit = 1'b1;
            default: ;
        endcase
        return hit;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    msc_seq_egress u_egress (
        .seq(cur.seq),
        .thresh(cur.thresh),
        .seq_next(eg_next),
        .rollover(eg_roll),
        .over_thresh(eg_thresh)
    );

    msc_replay_check u_replay (
        .next_pn(cur.seq),
        .window(cur.mask),
        .rx_pn(pkt_number),
        .advance(ig_advance),
        .replay_fail(ig_fail),
        .new_next(ig_new_next)
    );

    ////////////////////////////////////////////////////////////////////////
    assign is_ingress = cur.ctrl[msc_pkg::CW_SEQ_MASK]; // RQ8
    // Answer prepared in the setup cycle; if clk_en is high at its closing edge, the access phase never waits
    assign setup_req = psel && !penable;
    // Writes commit only at the edge that completes the access phase
    assign wr_acc = psel && penable && pwrite && cur.pready;
    assign rd_acc = setup_req && !pwrite;
    assign key_hit = key_range(paddr);
    assign key_idx = 4'((paddr - msc_pkg::OFF_KEY0) >> 2);

    always_comb begin
        next_cur = cur;
        next_cur.res_valid = 1'b0;
        next_cur.pready = 1'b0;
        next_cur.pslverr = 1'b0;
        if (setup_req) begin
            next_cur.pready = 1'b1;
            next_cur.pslverr = !addr_is_mapped(paddr);
        end
        // Register bus writes first so packet events below win over clears
        if (wr_acc) begin
            unique case (paddr)
                msc_pkg::OFF_CTRL: next_cur.ctrl = pwdata;
                msc_pkg::OFF_CTX_ID: next_cur.ctx_id = pwdata;
                msc_pkg::OFF_SEQ: next_cur.seq = pwdata;
                msc_pkg::OFF_MASK: next_cur.mask = pwdata;
                msc_pkg::OFF_SCI_LO: next_cur.sci_lo = pwdata; // RQ16
                msc_pkg::OFF_SCI_HI: next_cur.sci_hi = pwdata; // RQ16
                msc_pkg::OFF_THRESH: next_cur.thresh = pwdata;
                msc_pkg::OFF_INTR: begin
                    // Write one to clear status, enables in upper half
                    next_cur.int_status = cur.int_status &
                        ~pwdata[msc_pkg::INT_ROLL:msc_pkg::INT_THRESH]; // RQ23
                    next_cur.int_en = pwdata[msc_pkg::INT_EN_LO + 1:msc_pkg::INT_EN_LO];
                end
                msc_pkg::OFF_STATUS: begin
                    next_cur.seq_err_sticky = cur.seq_err_sticky & ~pwdata[0];
                    next_cur.replay_err_sticky = cur.replay_err_sticky & ~pwdata[1];
                end
                // Key words go to their own store; unmapped writes are dropped
                default: ;
            endcase
        end
        if (rd_acc) begin
            next_cur.prdata = msc_pkg::RST_ZERO;
            unique case (paddr)
                msc_pkg::OFF_CTRL: next_cur.prdata = cur.ctrl;
                msc_pkg::OFF_CTX_ID: next_cur.prdata = cur.ctx_id;
                msc_pkg::OFF_SEQ: next_cur.prdata = cur.seq;
                msc_pkg::OFF_MASK: next_cur.prdata = cur.mask;
                msc_pkg::OFF_SCI_LO: next_cur.prdata = cur.sci_lo;
                msc_pkg::OFF_SCI_HI: next_cur.prdata = cur.sci_hi;
                msc_pkg::OFF_THRESH: next_cur.prdata = cur.thresh;
                msc_pkg::OFF_INTR: begin
                    next_cur.prdata[msc_pkg::INT_ROLL:msc_pkg::INT_THRESH] = cur.int_status;
                    next_cur.prdata[msc_pkg::INT_EN_LO + 1:msc_pkg::INT_EN_LO] = cur.int_en;
                end
                msc_pkg::OFF_STATUS:
                    next_cur.prdata[1:0] = {cur.replay_err_sticky, cur.seq_err_sticky};
                // Key material is write-only; reads return zero
                default: next_cur.prdata = msc_pkg::RST_ZERO;
            endcase
        end
        // Packet processing against the context
        if (pkt_valid) begin
            next_cur.res_valid = 1'b1;
            next_cur.res_seq_error = 1'b0;
            next_cur.res_replay = 1'b0;
            next_cur.res_an = is_ingress ? 2'b00 :
                              cur.ctrl[msc_pkg::CW_AN_HI:msc_pkg::CW_AN_LO]; // RQ6
            next_cur.res_sci = {cur.sci_hi, cur.sci_lo}; // RQ16
            next_cur.res_key_256 = alg_is_256(cur.ctrl); // RQ4
            next_cur.res_alg_invalid = !alg_is_valid(cur.ctrl); // RQ4
            next_cur.res_pn = pkt_number;
            if (!is_ingress) begin
                if (eg_roll) begin
                    // Context left as is, so every later packet fails too
                    next_cur.res_seq_error = 1'b1; // RQ13
                    next_cur.seq_err_sticky = 1'b1; // RQ13
                    next_cur.int_status[1] = 1'b1; // RQ22
                    next_cur.res_pn = cur.seq;
                end else begin
                    next_cur.seq = eg_next; // RQ12
                    next_cur.res_pn = eg_next; // RQ12
                    if (eg_thresh) begin
                        next_cur.int_status[0] = 1'b1; // RQ21
                    end
                end
            end else if (ig_fail) begin
                next_cur.res_replay = 1'b1; // RQ20
                next_cur.replay_err_sticky = 1'b1; // RQ20
            end else if (ig_advance && cur.ctrl[msc_pkg::CW_UPD_SEQ]) begin
                next_cur.seq = ig_new_next; // RQ18
            end
        end
        next_cur.irq = |(next_cur.int_status & next_cur.int_en); // RQ23
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur <= '0;
            cur.seq <= msc_pkg::RST_SEQ_EGR;
            cur.mask <= msc_pkg::RST_ZERO; // RQ15
        end else if (clk_en) begin
            cur <= next_cur;
        end
    end

    // Key storage; a write of a key word lands whole, no byte reordering
    always_ff @(posedge pclk) begin
        if (clk_en && wr_acc && key_hit) begin
            key_mem[key_idx] <= pwdata; // RQ10
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign prdata = cur.prdata;
    assign pready = cur.pready;
    assign pslverr = cur.pslverr;
    assign res_valid = cur.res_valid;
    assign res_seq_error = cur.res_seq_error;
    assign res_replay_error_flag = cur.res_replay;
    assign res_packet_number = cur.res_pn;
    assign res_association_number = cur.res_an;
    assign res_secure_channel_identifier = cur.res_sci;
    assign res_key_256 = cur.res_key_256;
    assign res_alg_invalid = cur.res_alg_invalid;
    assign crypto_irq = cur.irq;
endmodule // msc_sa_context
`default_nettype wire

// >>> shared/msc_pkg.sv
package msc_pkg;
    // Context control word fields
    localparam int CW_IV0 = 5;
    localparam int CW_IV1 = 6;
    localparam int CW_IV2 = 7;
    localparam int CW_UPD_SEQ = 13;
    localparam int CW_IV_FMT = 14;
    localparam int CW_ENC_ICV = 15;
    localparam int CW_KEY_LOAD = 16;
    localparam int CW_ALG_LO = 17;
    localparam int CW_ALG_HI = 19;
    localparam int CW_AN_LO = 26;
    localparam int CW_AN_HI = 27;
    localparam int CW_SEQ_MASK = 30;
    localparam logic [2:0] ALG_AES128 = 3'h5;
    localparam logic [2:0] ALG_AES256 = 3'h7;
    // Record words, one aligned APB word each
    localparam int REC_WORDS = 20;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CTX_ID = 8'h04;
    localparam logic [7:0] OFF_KEY0 = 8'h08;
    localparam logic [7:0] OFF_SEQ = 8'h50;
    localparam logic [7:0] OFF_MASK = 8'h54;
    localparam logic [7:0] OFF_SCI_LO = 8'h58;
    localparam logic [7:0] OFF_SCI_HI = 8'h5c;
    localparam logic [7:0] OFF_THRESH = 8'h60;
    localparam logic [7:0] OFF_INTR = 8'h64;
    localparam logic [7:0] OFF_STATUS = 8'h68;
    localparam int KEY_WORDS = 8;
    localparam int HKEY_BASE = 8;
    localparam int HKEY_WORDS = 4;
    // Interrupt control/status layout
    localparam int INT_THRESH = 4;
    localparam int INT_ROLL = 5;
    localparam int INT_EN_LO = 16;
    localparam logic [31:0] SEQ_MAX = 32'hffff_ffff;
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam logic [31:0] RST_SEQ_EGR = 32'h0000_0000;
endpackage

// >>> hw/msc_seq_egress.sv
`timescale 1ns/1ps
`default_nettype none
module msc_seq_egress (
    input wire logic [31:0] seq,
    input wire logic [31:0] thresh,
    output logic [31:0] seq_next,
    output logic rollover,
    output logic over_thresh
);
    always_comb begin
        rollover = (seq == msc_pkg::SEQ_MAX); // RQ13
        seq_next = seq + 32'h0000_0001; // RQ12
        over_thresh = !rollover && (seq_next > thresh); // RQ21
    end
endmodule // msc_seq_egress
`default_nettype wire

// >>> hw/msc_replay_check.sv
`timescale 1ns/1ps
`default_nettype none
module msc_replay_check (
    input wire logic [31:0] next_pn,
    input wire logic [31:0] window,
    input wire logic [31:0] rx_pn,
    output logic advance,
    output logic replay_fail,
    output logic [31:0] new_next
);
    logic [32:0] low_edge;
    always_comb begin
        // Window may exceed next_pn; the floor then clamps at one
        low_edge = {1'b0, next_pn} - {1'b0, window};
        advance = (rx_pn >= next_pn); // RQ18
        // RQ19 accepted in window, RQ20 rejected below it; PN zero valid only if next_pn or the floor is zero
        replay_fail = !advance && (low_edge[32] ? (rx_pn == 32'h0000_0000)
                                                : (rx_pn < low_edge[31:0])); // RQ20
        new_next = rx_pn + 32'h0000_0001; // RQ18
    end
endmodule // msc_replay_check
`default_nettype wire

// >>> testbench/msc_sa_context_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module msc_sa_context_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic pkt_valid,
    input wire logic res_valid,
    input wire logic res_seq_error,
    input wire logic res_replay_error_flag,
    input wire logic [31:0] res_packet_number,
    input wire logic [1:0] res_association_number,
    input wire logic res_key_256,
    input wire logic res_alg_invalid,
    input wire logic crypto_irq
);
    // Shadow of irq enables, so irq is judged only when allowed
    logic [1:0] en;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            en <= 2'h0;
        else if (psel && penable && pready && pwrite && paddr == msc_pkg::OFF_INTR)
            en <= pwdata[17:16];
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////
    a_setup_gets_ready: assert property (psel && !penable && clk_en |=> pready)
        else $error("no pready after setup");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_pkt_gets_result: assert property (pkt_valid && clk_en |=> res_valid)
        else $error("no result after packet");
    a_key_size_decode: assert property (res_key_256 |-> !res_alg_invalid)
        else $error("256-bit key flagged invalid");
    a_wrap_keeps_pn: assert property (res_valid && res_seq_error |->
        res_packet_number == msc_pkg::SEQ_MAX) else $error("wrap changed number");
    a_one_error_kind: assert property (!(res_seq_error && res_replay_error_flag))
        else $error("both error kinds at once");
    a_ingress_no_an: assert property (res_replay_error_flag |-> !res_association_number)
        else $error("association number on ingress");
    a_wrap_raises_irq: assert property (res_valid && res_seq_error && en[1] |->
        ##[0:2] crypto_irq) else $error("no irq on wrap");
    a_irq_needs_enable: assert property (!en && !$past(en) |-> !crypto_irq)
        else $error("irq while disabled");
    c_wrap: cover property (res_valid && res_seq_error);
    c_replay: cover property (res_valid && res_replay_error_flag);
    c_irq: cover property ($rose(crypto_irq));
endmodule // msc_sa_context_assertions
bind msc_sa_context msc_sa_context_assertions chk_i (.pclk, .presetn, .clk_en, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .pkt_valid, .res_valid,
    .res_seq_error, .res_replay_error_flag, .res_packet_number, .res_association_number,
    .res_key_256, .res_alg_invalid, .crypto_irq);
`default_nettype wire

// >>> testbench/msc_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module msc_far_model (
    input wire logic pclk,
    output logic pkt_valid,
    output logic [31:0] pkt_number
);
    initial begin
        pkt_valid = 1'b0;
        pkt_number = 32'h0000_0000;
    end
    // One packet; number inverted after so stale values never match
    task automatic send(input logic [31:0] pn);
        @(posedge pclk);
        pkt_valid <= 1'b1;
        pkt_number <= pn;
        @(posedge pclk);
        pkt_valid <= 1'b0;
        pkt_number <= ~pn;
        #1;
    endtask
endmodule // msc_far_model
`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, pkt_number, res_packet_number, rd;
    logic pready, pslverr, pkt_valid, res_valid, res_seq_error, res_replay_error_flag;
    logic res_key_256, res_alg_invalid, crypto_irq;
    logic [1:0] res_association_number;
    logic [63:0] res_secure_channel_identifier;
    int mismatches = 0;
    int samples_checked = 0;
    localparam logic [31:0] EGR = 32'h9a4b_e060;
    localparam logic [31:0] ING = 32'hd24b_e060;
    always #4 pclk = ~pclk;
    msc_sa_context uut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .pkt_valid, .pkt_number, .res_valid,
        .res_seq_error, .res_replay_error_flag, .res_packet_number,
        .res_association_number, .res_secure_channel_identifier, .res_key_256,
        .res_alg_invalid, .crypto_irq);
    msc_far_model far (.pclk, .pkt_valid, .pkt_number);
    ////////////////////////////////////////
    task end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask
    task chk1(input string nm, input logic s, input logic e);
        chk(nm, {31'h0, s}, {31'h0, e});
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            mismatches++;
            end_of_test();
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, rd, e);
    endtask
    task pk(input logic [31:0] pn);
        far.send(pn);
        chk1("res_valid", res_valid, 1'b1);
    endtask
    ////////////////////////////////////////
    task t_regs;
        rdc("mask", msc_pkg::OFF_MASK, 32'h0000_0000);
        rdc("seq", msc_pkg::OFF_SEQ, 32'h0000_0000);
        wr(msc_pkg::OFF_KEY0, 32'h0403_0201);
        rdc("key0", msc_pkg::OFF_KEY0, 32'h0000_0000);
        chk1("pslverr", err, 1'b0);
        for (int i = 0; i < msc_pkg::HKEY_WORDS; i++) begin
            wr(8'(msc_pkg::OFF_KEY0 + 4 * (msc_pkg::HKEY_BASE + i)), 32'h0000_0000);
            chk1("pslverr", err, 1'b0);
        end
        apb(1'b1, 8'(msc_pkg::OFF_KEY0 + 4 * (msc_pkg::KEY_WORDS + msc_pkg::HKEY_WORDS)),
            32'h0000_0000);
        chk1("pslverr", err, 1'b1);
        apb(1'b0, 8'h7c, 32'h0000_0000);
        chk1("pslverr", err, 1'b1);
        $display("test regs done");
    endtask
    task t_egress;
        wr(msc_pkg::OFF_CTRL, EGR);
        wr(msc_pkg::OFF_THRESH, 32'h0000_0001);
        wr(msc_pkg::OFF_SCI_LO, 32'h1111_2222);
        wr(msc_pkg::OFF_SCI_HI, 32'h3333_4444);
        wr(msc_pkg::OFF_INTR, 32'h0003_0000);
        pk(32'h0000_0007);
        chk("pn", res_packet_number, 32'h0000_0001);
        chk("an", {30'h0, res_association_number}, 32'h0000_0002);
        chk("sci", res_secure_channel_identifier[63:32] ^ 32'h3333_4444, 0);
        chk("sci", res_secure_channel_identifier[31:0], 32'h1111_2222);
        rdc("intr", msc_pkg::OFF_INTR, 32'h0003_0000);
        pk(32'h0000_0007);
        chk("pn", res_packet_number, 32'h0000_0002);
        rdc("intr", msc_pkg::OFF_INTR, 32'h0003_0010);
        chk1("irq", crypto_irq, 1'b1);
        wr(msc_pkg::OFF_INTR, 32'h0003_0010);
        rdc("intr", msc_pkg::OFF_INTR, 32'h0003_0000);
        chk1("irq", crypto_irq, 1'b0);
        wr(msc_pkg::OFF_SEQ, 32'hffff_fffe);
        pk(32'h0000_0000);
        chk("pn", res_packet_number, 32'hffff_ffff);
        chk1("seq_err", res_seq_error, 1'b0);
        for (int i = 0; i < 2; i++) begin
            pk(32'h0000_0000);
            chk1("seq_err", res_seq_error, 1'b1);
        end
        rdc("seq", msc_pkg::OFF_SEQ, 32'hffff_ffff);
        rdc("status", msc_pkg::OFF_STATUS, 32'h0000_0001);
        rdc("intr", msc_pkg::OFF_INTR, 32'h0003_0030);
        wr(msc_pkg::OFF_INTR, 32'h0000_0030);
        rdc("intr", msc_pkg::OFF_INTR, 32'h0000_0000);
        chk1("irq", crypto_irq, 1'b0);
        $display("test egress done");
    endtask
    task t_alg;
        logic [2:0] a [3];
        a = '{3'h7, 3'h5, 3'h0};
        for (int i = 0; i < 3; i++) begin
            wr(msc_pkg::OFF_CTRL, {EGR[31:20], a[i], EGR[16:0]});
            pk(32'h0000_0000);
            chk1("key_256", res_key_256, a[i] == 3'h7);
            chk1("alg_inv", res_alg_invalid, a[i] != 3'h5 && a[i] != 3'h7);
        end
        $display("test algorithm done");
    endtask
    task t_ingress;
        wr(msc_pkg::OFF_CTRL, ING);
        wr(msc_pkg::OFF_SEQ, 32'h0000_0001);
        pk(32'h0000_0005);
        chk1("replay", res_replay_error_flag, 1'b0);
        chk("an", {30'h0, res_association_number}, 32'h0000_0000);
        chk("pn", res_packet_number, 32'h0000_0005);
        rdc("seq", msc_pkg::OFF_SEQ, 32'h0000_0006);
        pk(32'h0000_0005);
        chk1("replay", res_replay_error_flag, 1'b1);
        rdc("status", msc_pkg::OFF_STATUS, 32'h0000_0003);
        wr(msc_pkg::OFF_MASK, 32'h0000_0002);
        pk(32'h0000_0004);
        chk1("replay", res_replay_error_flag, 1'b0);
        rdc("seq", msc_pkg::OFF_SEQ, 32'h0000_0006);
        pk(32'h0000_0003);
        chk1("replay", res_replay_error_flag, 1'b1);
        rdc("seq", msc_pkg::OFF_SEQ, 32'h0000_0006);
        wr(msc_pkg::OFF_MASK, 32'hffff_ffff);
        pk(32'h0000_0001);
        chk1("replay", res_replay_error_flag, 1'b0);
        // Frozen clock enable: a packet must leave no trace
        @(posedge pclk);
        clk_en <= 1'b0;
        far.send(32'h0000_0020);
        chk1("res_valid", res_valid, 1'b0);
        @(posedge pclk);
        clk_en <= 1'b1;
        rdc("seq", msc_pkg::OFF_SEQ, 32'h0000_0006);
        // Update flag off: in-order number must not move the context
        wr(msc_pkg::OFF_CTRL, ING & 32'hffff_dfff);
        pk(32'h0000_0009);
        rdc("seq", msc_pkg::OFF_SEQ, 32'h0000_0006);
        $display("test ingress done");
    endtask
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_egress();
        t_alg();
        t_ingress();
        end_of_test();
    end
endmodule // testbench
`default_nettype wire
